/* File: rss_cfg.svh */
// constants for the rotate, subtract and skip execution block
// How it works
// - rotate left into accumulator, flags untouched
// - rotate memory left through carry
// - rotate left through carry into accumulator
// - rotate memory right, no flag change
// - rotate right into accumulator, flags untouched
// - rotate memory right through carry
// - rotate right through carry into accumulator
// - subtract with borrow into accumulator, flags
// - subtract with borrow into memory, flags
// - subtract carry set means no borrow
// - decrement memory, skip when zero
// - decrement into accumulator, skip when zero
// - increment memory, skip when zero
// - increment into accumulator, skip when zero
// - skip when selected memory bit set
// - taken skip adds one dummy cycle
// - byte set writes all ones
// - bit set forces one selected bit
// - subtract memory from accumulator, flags
// - subtract into memory, accumulator kept
// - subtract immediate from accumulator, flags
// - nibble swap in place or into accumulator
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH

`define RSS_ADDR_W      8
`define RSS_OFS_CMD     8'h00
`define RSS_OFS_ACC     8'h04
`define RSS_OFS_MEM     8'h08
`define RSS_OFS_FLAGS   8'h0c
`define RSS_OFS_STAT    8'h10

`define RSS_CMD_OP      4:0
`define RSS_CMD_BIT     7:5
`define RSS_CMD_IMM     15:8

`define RSS_FLG_C       0
`define RSS_FLG_AC      1
`define RSS_FLG_Z       2
`define RSS_FLG_OV      3

`define RSS_STAT_BUSY   0
`define RSS_STAT_SKIP   1
`define RSS_STAT_DUMMY  2

`define RSS_ACC_RST     8'h00
`define RSS_MEM_RST     8'h00
`define RSS_FLAGS_RST   4'h0

`define RSS_RESP_OKAY   2'b00
`define RSS_RESP_SLVERR 2'b10

`endif

/* File: rss_pkg.sv */
// types shared by the execution block and its arithmetic unit
`include "rss_cfg.svh"
package rss_pkg;

    typedef enum logic [4:0] {
        RSS_OP_NOP            = 5'h00,
        RSS_OP_ROTL_ACC       = 5'h01,
        RSS_OP_ROTL_C         = 5'h02,
        RSS_OP_ROTL_C_ACC     = 5'h03,
        RSS_OP_ROTR           = 5'h04,
        RSS_OP_ROTR_ACC       = 5'h05,
        RSS_OP_ROTR_C         = 5'h06,
        RSS_OP_ROTR_C_ACC     = 5'h07,
        RSS_OP_SUB_BORROW     = 5'h08,
        RSS_OP_SUB_BORROW_MEM = 5'h09,
        RSS_OP_DEC_SKIP       = 5'h0a,
        RSS_OP_DEC_SKIP_ACC   = 5'h0b,
        RSS_OP_INC_SKIP       = 5'h0c,
        RSS_OP_INC_SKIP_ACC   = 5'h0d,
        RSS_OP_SKIP_BIT_SET   = 5'h0e,
        RSS_OP_SET_BYTE       = 5'h0f,
        RSS_OP_SET_BIT        = 5'h10,
        RSS_OP_SUB            = 5'h11,
        RSS_OP_SUB_MEM        = 5'h12,
        RSS_OP_SUB_IMM        = 5'h13,
        RSS_OP_SWAP           = 5'h14,
        RSS_OP_SWAP_ACC       = 5'h15
    } rss_op_t;

    typedef enum logic [2:0] {
        RSS_ST_IDLE  = 3'b001,
        RSS_ST_EXEC  = 3'b010,
        RSS_ST_DUMMY = 3'b100
    } rss_state_t;

    typedef struct packed {
        logic overflow_flag;
        logic zero;
        logic aux_carry_flag;
        logic carry;
    } rss_flags_t;

    typedef struct packed {
        logic       acc_we;
        logic [7:0] acc_val;
        logic       mem_we;
        logic [7:0] mem_val;
        logic       carry_we;
        logic       arith_we;
        rss_flags_t flags;
        logic       skip;
    } rss_alu_res_t;

    typedef struct packed {
        logic [`RSS_ADDR_W-1:0] addr;
        logic [2:0]             prot;
    } rss_axi_addr_t;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  strb;
    } rss_axi_w_t;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0]  resp;
    } rss_axi_r_t;

endpackage

/* File: rss_alu.sv */
// combinational result and flag logic for one instruction
`timescale 1ns/1ps
module rss_alu (
    input  wire rss_pkg::rss_op_t     op,
    input  wire logic [7:0]           acc,
    input  wire logic [7:0]           mem,
    input  wire logic [7:0]           imm,
    input  wire logic [2:0]           bit_sel,
    input  wire logic                 carry,
    output rss_pkg::rss_alu_res_t     res
);
    import rss_pkg::*;

    logic [7:0] sub_b;
    logic       borrow_in;
    logic [8:0] diff;
    logic [4:0] low_diff;
    logic [7:0] dec_val;
    logic [7:0] inc_val;

    // subtrahend is the immediate only for the immediate form; borrow only for borrow forms
    assign sub_b     = (op == RSS_OP_SUB_IMM) ? imm : mem;
    assign borrow_in = (op == RSS_OP_SUB_BORROW || op == RSS_OP_SUB_BORROW_MEM) ? ~carry : 1'b0;
    assign diff      = {1'b0, acc} - {1'b0, sub_b} - {8'h00, borrow_in};
    assign low_diff  = {1'b0, acc[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, borrow_in};
    assign dec_val   = mem - 8'h01;
    assign inc_val   = mem + 8'h01;

    // one decode for every opcode; unknown codes behave as no operation
    always_comb
    begin
        res = '0;
        res.flags.carry          = ~diff[8];
        res.flags.aux_carry_flag = ~low_diff[4];
        res.flags.overflow_flag  = (acc[7] ^ sub_b[7]) & (acc[7] ^ diff[7]);
        res.flags.zero           = (diff[7:0] == 8'h00);
        unique case (op)
            RSS_OP_ROTL_ACC: begin res.acc_we = 1'b1; res.acc_val = {mem[6:0], mem[7]}; end
            RSS_OP_ROTL_C:
            begin
                res.mem_we      = 1'b1;
                res.mem_val     = {mem[6:0], carry};
                res.carry_we    = 1'b1;
                res.flags.carry = mem[7];
            end
            RSS_OP_ROTL_C_ACC:
            begin
                res.acc_we      = 1'b1;
                res.acc_val     = {mem[6:0], carry};
                res.carry_we    = 1'b1;
                res.flags.carry = mem[7];
            end
            RSS_OP_ROTR: begin res.mem_we = 1'b1; res.mem_val = {mem[0], mem[7:1]}; end
            RSS_OP_ROTR_ACC: begin res.acc_we = 1'b1; res.acc_val = {mem[0], mem[7:1]}; end
            RSS_OP_ROTR_C:
            begin
                res.mem_we      = 1'b1;
                res.mem_val     = {carry, mem[7:1]};
                res.carry_we    = 1'b1;
                res.flags.carry = mem[0];
            end
            RSS_OP_ROTR_C_ACC:
            begin
                res.acc_we      = 1'b1;
                res.acc_val     = {carry, mem[7:1]};
                res.carry_we    = 1'b1;
                res.flags.carry = mem[0];
            end
            RSS_OP_SUB_BORROW, RSS_OP_SUB, RSS_OP_SUB_IMM:
            begin
                res.acc_we   = 1'b1;
                res.acc_val  = diff[7:0];
                res.arith_we = 1'b1;
            end
            RSS_OP_SUB_BORROW_MEM, RSS_OP_SUB_MEM:
            begin
                res.mem_we   = 1'b1;
                res.mem_val  = diff[7:0];
                res.arith_we = 1'b1;
            end
            RSS_OP_DEC_SKIP: begin res.mem_we = 1'b1; res.mem_val = dec_val; res.skip = (dec_val == 8'h00); end
            RSS_OP_DEC_SKIP_ACC: begin res.acc_we = 1'b1; res.acc_val = dec_val; res.skip = (dec_val == 8'h00); end
            RSS_OP_INC_SKIP: begin res.mem_we = 1'b1; res.mem_val = inc_val; res.skip = (inc_val == 8'h00); end
            RSS_OP_INC_SKIP_ACC: begin res.acc_we = 1'b1; res.acc_val = inc_val; res.skip = (inc_val == 8'h00); end
            RSS_OP_SKIP_BIT_SET: res.skip = mem[bit_sel];
            RSS_OP_SET_BYTE: begin res.mem_we = 1'b1; res.mem_val = 8'hff; end
            RSS_OP_SET_BIT:
            begin
                res.mem_we           = 1'b1;
                res.mem_val          = mem;
                res.mem_val[bit_sel] = 1'b1;
            end
            RSS_OP_SWAP: begin res.mem_we = 1'b1; res.mem_val = {mem[3:0], mem[7:4]}; end
            RSS_OP_SWAP_ACC: begin res.acc_we = 1'b1; res.acc_val = {mem[3:0], mem[7:4]}; end
            default: res.skip = 1'b0;
        endcase
    end

endmodule

/* File: rss_core.sv */
// execution block with AXI4-Lite register access and instruction sequencing
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "rss_cfg.svh"
module rss_core (
    input  wire logic                  sys_clk,
    input  wire logic                  srst,
    input  wire logic                  s_awvalid,
    output logic                       s_awready,
    input  wire rss_pkg::rss_axi_addr_t s_aw,
    input  wire logic                  s_wvalid,
    output logic                       s_wready,
    input  wire rss_pkg::rss_axi_w_t   s_w,
    output logic                       s_bvalid,
    input  wire logic                  s_bready,
    output logic [1:0]                 s_bresp,
    input  wire logic                  s_arvalid,
    output logic                       s_arready,
    input  wire rss_pkg::rss_axi_addr_t s_ar,
    output logic                       s_rvalid,
    input  wire logic                  s_rready,
    output rss_pkg::rss_axi_r_t        s_r,
    output logic                       busy,
    output logic                       dummy_cycle,
    output logic                       mem_wr_pulse,
    output logic [7:0]                 mem_wr_byte,
    output logic [7:0]                 acc_byte,
    output rss_pkg::rss_flags_t        flags
);
    import rss_pkg::*;

    rss_state_t    state_r;
    rss_state_t    state_nxt;
    rss_op_t       op_r;
    logic [2:0]    bit_r;
    logic [7:0]    imm_r;
    logic [7:0]    acc_r;
    logic [7:0]    mem_r;
    rss_flags_t    flags_r;
    logic          skip_r;
    logic          mem_wr_r;
    rss_alu_res_t  alu_res;

    rss_axi_addr_t aw_r;
    rss_axi_w_t    w_r;
    logic          aw_have_r;
    logic          w_have_r;
    logic          bvalid_r;
    logic [1:0]    bresp_r;
    logic          rvalid_r;
    rss_axi_r_t    r_r;

    logic          idle;
    logic          exec;
    logic          wr_fire;
    logic          wr_mapped;
    logic          wr_ok;
    logic          cmd_go;
    logic          wr_acc;
    logic          wr_mem;
    logic          wr_flags;
    logic          rd_fire;

    assign idle = (state_r == RSS_ST_IDLE);
    assign exec = (state_r == RSS_ST_EXEC);

    // arithmetic and result selection for the latched instruction
    rss_alu u_alu (
        .op      (op_r),
        .acc     (acc_r),
        .mem     (mem_r),
        .imm     (imm_r),
        .bit_sel (bit_r),
        .carry   (flags_r.carry),
        .res     (alu_res)
    );

    // write channels are taken independently; each slot holds one item until the write completes
    assign s_awready = ~aw_have_r;
    assign s_wready  = ~w_have_r;
    assign wr_fire   = aw_have_r & w_have_r & ~bvalid_r;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            aw_have_r <= 1'b0;
            aw_r      <= '0;
        end
        else if (s_awvalid && s_awready)
        begin
            aw_have_r <= 1'b1;
            aw_r      <= s_aw;
        end
        else if (wr_fire)
        begin
            aw_have_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            w_have_r <= 1'b0;
            w_r      <= '0;
        end
        else if (s_wvalid && s_wready)
        begin
            w_have_r <= 1'b1;
            w_r      <= s_w;
        end
        else if (wr_fire)
        begin
            w_have_r <= 1'b0;
        end
    end

    // register writes are refused while an instruction runs, so execution never races software
    always_comb
    begin
        wr_mapped = (aw_r.addr == `RSS_OFS_CMD) || (aw_r.addr == `RSS_OFS_ACC) ||
                    (aw_r.addr == `RSS_OFS_MEM) || (aw_r.addr == `RSS_OFS_FLAGS) ||
                    (aw_r.addr == `RSS_OFS_STAT);
        wr_ok     = wr_mapped && idle && (aw_r.addr != `RSS_OFS_STAT);
        cmd_go    = wr_fire && wr_ok && (aw_r.addr == `RSS_OFS_CMD) && w_r.strb[0];
        wr_acc    = wr_fire && wr_ok && (aw_r.addr == `RSS_OFS_ACC) && w_r.strb[0];
        wr_mem    = wr_fire && wr_ok && (aw_r.addr == `RSS_OFS_MEM) && w_r.strb[0];
        wr_flags  = wr_fire && wr_ok && (aw_r.addr == `RSS_OFS_FLAGS) && w_r.strb[0];
    end

    // write response: error for unmapped, read-only or busy-time writes
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            bvalid_r <= 1'b0;
            bresp_r  <= `RSS_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_ok ? `RSS_RESP_OKAY : `RSS_RESP_SLVERR;
        end
        else if (s_bready)
        begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_bvalid = bvalid_r;
    assign s_bresp  = bresp_r;

    // read channel: one read in flight, data registered at the address handshake
    assign s_arready = ~rvalid_r;
    assign rd_fire   = s_arvalid & ~rvalid_r;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            rvalid_r <= 1'b0;
            r_r      <= '0;
        end
        else if (rd_fire)
        begin
            rvalid_r    <= 1'b1;
            r_r.data    <= 32'h0000_0000;
            r_r.resp    <= `RSS_RESP_OKAY;
            unique case (s_ar.addr)
                `RSS_OFS_CMD:   r_r.data[15:0] <= {imm_r, bit_r, op_r};
                `RSS_OFS_ACC:   r_r.data[7:0]  <= acc_r;
                `RSS_OFS_MEM:   r_r.data[7:0]  <= mem_r;
                `RSS_OFS_FLAGS: r_r.data[3:0]  <= flags_r;
                `RSS_OFS_STAT:  r_r.data[2:0]  <= {dummy_cycle, skip_r, ~idle};
                default:        r_r.resp       <= `RSS_RESP_SLVERR;
            endcase
        end
        else if (s_rready)
        begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_rvalid = rvalid_r;
    assign s_r      = r_r;

    // instruction fields are latched when the command register is written
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            op_r  <= RSS_OP_NOP;
            bit_r <= 3'h0;
            imm_r <= 8'h00;
        end
        else if (cmd_go)
        begin
            op_r  <= rss_op_t'(w_r.data[`RSS_CMD_OP]);
            bit_r <= w_r.data[`RSS_CMD_BIT];
            imm_r <= w_r.strb[1] ? w_r.data[`RSS_CMD_IMM] : 8'h00;
        end
    end

    // sequencing: one execute cycle, plus a dummy cycle when the instruction skips
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            RSS_ST_IDLE:  if (cmd_go) state_nxt = RSS_ST_EXEC;
            RSS_ST_EXEC:  state_nxt = alu_res.skip ? RSS_ST_DUMMY : RSS_ST_IDLE;
            RSS_ST_DUMMY: state_nxt = RSS_ST_IDLE;
            default:      state_nxt = RSS_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            state_r <= RSS_ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // skip outcome of the last instruction stays readable until the next one runs
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            skip_r <= 1'b0;
        else if (exec)
            skip_r <= alu_res.skip;
    end

    // accumulator: instruction result has priority, software loads only while idle
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            acc_r <= `RSS_ACC_RST;
        else if (exec && alu_res.acc_we)
            acc_r <= alu_res.acc_val;
        else if (wr_acc)
            acc_r <= w_r.data[7:0];
    end

    // data memory byte under operation and its write-back strobe toward the core
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            mem_r    <= `RSS_MEM_RST;
            mem_wr_r <= 1'b0;
        end
        else
        begin
            mem_wr_r <= exec && alu_res.mem_we;
            if (exec && alu_res.mem_we)
                mem_r <= alu_res.mem_val;
            else if (wr_mem)
                mem_r <= w_r.data[7:0];
        end
    end

    // status flags: rotates through carry touch carry only, subtractions touch all four
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            flags_r <= `RSS_FLAGS_RST;
        else if (exec && alu_res.arith_we)
            flags_r <= alu_res.flags;
        else if (exec && alu_res.carry_we)
            flags_r.carry <= alu_res.flags.carry;
        else if (wr_flags)
            flags_r <= w_r.data[3:0];
    end

    assign busy         = ~idle;
    assign dummy_cycle  = (state_r == RSS_ST_DUMMY);
    assign mem_wr_pulse = mem_wr_r;
    assign mem_wr_byte  = mem_r;
    assign acc_byte     = acc_r;
    assign flags        = flags_r;

    // checks on committed results, one cycle after the execute cycle
    AST_ROTL_ACC: assert property (@(posedge sys_clk) disable iff (srst)
        exec && op_r == RSS_OP_ROTL_ACC |=> acc_r == {$past(mem_r[6:0]), $past(mem_r[7])}
        && mem_r == $past(mem_r) && flags_r == $past(flags_r))
        else $error("rotate left to accumulator result wrong");

    AST_ROTL_C: assert property (@(posedge sys_clk) disable iff (srst)
        exec && op_r == RSS_OP_ROTL_C |=> mem_r == {$past(mem_r[6:0]), $past(flags_r.carry)}
        && flags_r.carry == $past(mem_r[7]) && mem_wr_pulse)
        else $error("rotate left through carry wrong");

    AST_ROTR_C_ACC: assert property (@(posedge sys_clk) disable iff (srst)
        exec && op_r == RSS_OP_ROTR_C_ACC |=> acc_r == {$past(flags_r.carry), $past(mem_r[7:1])}
        && flags_r.carry == $past(mem_r[0]) && mem_r == $past(mem_r))
        else $error("rotate right through carry to accumulator wrong");

    AST_ROTR: assert property (@(posedge sys_clk) disable iff (srst)
        exec && op_r == RSS_OP_ROTR |=> mem_r == {$past(mem_r[0]), $past(mem_r[7:1])}
        && flags_r == $past(flags_r))
        else $error("rotate right wrong");

    AST_SUB_BORROW: assert property (@(posedge sys_clk) disable iff (srst)
        exec && op_r == RSS_OP_SUB_BORROW |=>
        acc_r == 8'($past(acc_r) - $past(mem_r) - {7'h00, ~$past(flags_r.carry)}))
        else $error("subtract with borrow result wrong");

    AST_SUB_CARRY: assert property (@(posedge sys_clk) disable iff (srst)
        exec && op_r == RSS_OP_SUB_MEM |=> flags_r.carry == ($past(acc_r) >= $past(mem_r))
        && flags_r.zero == (mem_r == 8'h00) && acc_r == $past(acc_r))
        else $error("subtract carry or zero wrong");

    AST_SKIP_BIT: assert property (@(posedge sys_clk) disable iff (srst)
        exec && op_r == RSS_OP_SKIP_BIT_SET |=> skip_r == $past(mem_r[bit_r]) && mem_r == $past(mem_r))
        else $error("bit test skip wrong");

    AST_SKIP_DUMMY: assert property (@(posedge sys_clk) disable iff (srst)
        exec && alu_res.skip |=> dummy_cycle ##1 idle)
        else $error("taken skip did not last two cycles");

    AST_NO_SKIP: assert property (@(posedge sys_clk) disable iff (srst)
        exec && !alu_res.skip |=> idle && !dummy_cycle)
        else $error("untaken skip inserted a dummy cycle");

    AST_SET_BYTE: assert property (@(posedge sys_clk) disable iff (srst)
        exec && op_r == RSS_OP_SET_BYTE |=> mem_r == 8'hff && flags_r == $past(flags_r))
        else $error("byte set wrong");

    AST_SWAP_ACC: assert property (@(posedge sys_clk) disable iff (srst)
        exec && op_r == RSS_OP_SWAP_ACC |=> acc_r == {$past(mem_r[3:0]), $past(mem_r[7:4])}
        && mem_r == $past(mem_r))
        else $error("nibble swap to accumulator wrong");

endmodule

/* File: rss_host_model.sv */
// axi4-lite master standing in for the software that loads and starts the core
`timescale 1ns/1ps
module rss_host_model (
    input  wire logic                 sys_clk,
    output logic                      s_awvalid,
    input  wire logic                 s_awready,
    output rss_pkg::rss_axi_addr_t    s_aw,
    output logic                      s_wvalid,
    input  wire logic                 s_wready,
    output rss_pkg::rss_axi_w_t       s_w,
    input  wire logic                 s_bvalid,
    output logic                      s_bready,
    input  wire logic [1:0]           s_bresp,
    output logic                      s_arvalid,
    input  wire logic                 s_arready,
    output rss_pkg::rss_axi_addr_t    s_ar,
    input  wire logic                 s_rvalid,
    output logic                      s_rready,
    input  wire rss_pkg::rss_axi_r_t  s_r
);
    import rss_pkg::*;

    // quiet bus from time zero
    initial
    begin
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
        s_aw = '0;
        s_w = '0;
        s_ar = '0;
    end

    // one write; each channel dropped only at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        @(posedge sys_clk);
        s_aw <= '{a, 3'h0};
        s_w <= '{d, 4'hf};
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        forever
        begin
            @(posedge sys_clk);
            if (s_awready)
                s_awvalid <= 1'b0;
            if (s_wready)
                s_wvalid <= 1'b0;
            if (s_bvalid)
            begin
                resp = s_bresp;
                s_bready <= 1'b0;
                break;
            end
        end
    endtask

    // one read; no wait is assumed, the bench watchdog ends a hang
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge sys_clk);
        s_ar <= '{a, 3'h0};
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        forever
        begin
            @(posedge sys_clk);
            if (s_arready)
                s_arvalid <= 1'b0;
            if (s_rvalid)
            begin
                d = s_r.data;
                resp = s_r.resp;
                s_rready <= 1'b0;
                break;
            end
        end
    endtask
endmodule

/* File: rss_core_tb.sv */
// self-checking bench for the rotate, subtract and skip block
`timescale 1ns/1ps
module rss_core_tb;
    import rss_pkg::*;

    logic           sys_clk;
    logic           srst;
    logic           s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic           s_arvalid, s_arready, s_rvalid, s_rready, busy, dummy_cycle, mem_wr_pulse;
    logic [1:0]     s_bresp;
    logic [7:0]     mem_wr_byte, acc_byte;
    rss_axi_addr_t  s_aw, s_ar;
    rss_axi_w_t     s_w;
    rss_axi_r_t     s_r;
    rss_flags_t     flags;
    int             bad_count = 0, cmp_count = 0, bcnt = 0, dcnt = 0, wcnt = 0;

    rss_core u_rss_core (
        .sys_clk, .srst, .s_awvalid, .s_awready, .s_aw, .s_wvalid, .s_wready, .s_w, .s_bvalid,
        .s_bready, .s_bresp, .s_arvalid, .s_arready, .s_ar, .s_rvalid, .s_rready, .s_r,
        .busy, .dummy_cycle, .mem_wr_pulse, .mem_wr_byte, .acc_byte, .flags
    );

    rss_host_model u_rss_host_model (
        .sys_clk, .s_awvalid, .s_awready, .s_aw, .s_wvalid, .s_wready, .s_w, .s_bvalid,
        .s_bready, .s_bresp, .s_arvalid, .s_arready, .s_ar, .s_rvalid, .s_rready, .s_r
    );

    // 40 mhz clock
    initial
    begin
        sys_clk = 1'b0;
        forever
            #12.5 sys_clk = ~sys_clk;
    end

    // busy and dummy cycles, so instruction length is measured not assumed
    always @(posedge sys_clk)
    begin
        bcnt <= bcnt + busy;
        dcnt <= dcnt + dummy_cycle;
        wcnt <= wcnt + mem_wr_pulse;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("counts: %0d compared, %0d mismatched", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    function automatic void model(input logic [4:0] op, input logic [7:0] a, m, input logic [2:0] b,
        input logic [3:0] f, output logic [7:0] ea, em, output logic [3:0] ef, output logic sk);
        logic [8:0] d;
        logic [4:0] n;
        logic bi;
        bi = (op == 5'h08 || op == 5'h09) && !f[0];
        d = {1'b0, a} - {1'b0, m} - bi;
        n = {1'b0, a[3:0]} - {1'b0, m[3:0]} - bi;
        ea = a;
        em = m;
        ef = f;
        case (op)
            5'h01: ea = {m[6:0], m[7]};
            5'h02: {ef[0], em} = {m, f[0]};
            5'h03: {ef[0], ea} = {m, f[0]};
            5'h04: em = {m[0], m[7:1]};
            5'h05: ea = {m[0], m[7:1]};
            5'h06: {em, ef[0]} = {f[0], m};
            5'h07: {ea, ef[0]} = {f[0], m};
            5'h08, 5'h11, 5'h13: ea = d[7:0];
            5'h09, 5'h12: em = d[7:0];
            5'h0a: em = m - 8'h01;
            5'h0b: ea = m - 8'h01;
            5'h0c: em = m + 8'h01;
            5'h0d: ea = m + 8'h01;
            5'h0f: em = 8'hff;
            5'h10: em[b] = 1'b1;
            5'h14: em = {m[3:0], m[7:4]};
            5'h15: ea = {m[3:0], m[7:4]};
            default: ;
        endcase
        if (op inside {5'h08, 5'h09, 5'h11, 5'h12, 5'h13})
            ef = {a[7] != m[7] && d[7] != a[7], d[7:0] == 8'h00, ~n[4], ~d[8]};
        sk = (op inside {5'h0a, 5'h0b} && m == 8'h01) || (op inside {5'h0c, 5'h0d} && m == 8'hff)
            || (op == 5'h0e && m[b]);
    endfunction

    // one instruction; the immediate byte carries the same value as memory
    task automatic run_op(input logic [4:0] op, input logic [7:0] a, m, input logic [2:0] b, input logic c);
        logic [7:0] ea, em;
        logic [3:0] ef;
        logic [31:0] rd;
        logic [1:0] rs;
        logic sk;
        int b0, d0, w0;
        model(op, a, m, b, {3'b101, c}, ea, em, ef, sk);
        u_rss_host_model.wr(8'h08, {24'h0, m}, rs);
        u_rss_host_model.wr(8'h04, {24'h0, a}, rs);
        u_rss_host_model.wr(8'h0c, {28'h0, 3'b101, c}, rs);
        b0 = bcnt;
        d0 = dcnt;
        w0 = wcnt;
        u_rss_host_model.wr(8'h00, {16'h0, m, b, op}, rs);
        repeat (4) @(posedge sys_clk);
        chk(acc_byte, ea);
        chk(mem_wr_byte, em);
        chk(flags, ef);
        chk(bcnt - b0, 1 + sk);
        chk(dcnt - d0, sk);
        chk(wcnt - w0, op inside {5'h02, 5'h04, 5'h06, 5'h09, 5'h0a, 5'h0c, 5'h0f, 5'h10, 5'h12, 5'h14});
        u_rss_host_model.rd(8'h10, rd, rs);
        chk(rd[1], sk);
    endtask

    // every opcode, plus one unassigned, over one operand set
    task automatic ops_test(input int i);
        logic [7:0] ta [4] = '{8'h3c, 8'h80, 8'h10, 8'h05};
        logic [7:0] tm [4] = '{8'h81, 8'h01, 8'hff, 8'h05};
        logic [2:0] tbit [4] = '{3'd7, 3'd1, 3'd3, 3'd0};
        logic [3:0] tc = 4'b1101;
        for (int op = 0; op < 23; op++)
            run_op(op[4:0], ta[i], tm[i], tbit[i], tc[i]);
        $display("test operand set %0d done", i);
    endtask

    // refused accesses, then a plain register round trip
    task automatic err_test;
        logic [31:0] rd;
        logic [1:0] rs;
        u_rss_host_model.wr(8'h14, 32'h0, rs);
        chk(rs, 2'b10);
        u_rss_host_model.wr(8'h10, 32'h0, rs);
        chk(rs, 2'b10);
        u_rss_host_model.rd(8'h01, rd, rs);
        chk(rs, 2'b10);
        chk(rd, 32'h0);
        u_rss_host_model.wr(8'h04, 32'h5a, rs);
        u_rss_host_model.rd(8'h04, rd, rs);
        chk(rd, 32'h5a);
        $display("test bus errors done");
    endtask

    // cuts a hang short; the full run needs a few thousand cycles
    initial
    begin
        #(25 * 20000);
        bad_count++;
        end_of_test();
    end

    // main sequence
    initial
    begin
        srst = 1'b1;
        repeat (16) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        chk({busy, flags, acc_byte, mem_wr_byte}, 32'h0);
        for (int i = 0; i < 4; i++)
            ops_test(i);
        err_test();
        end_of_test();
    end
endmodule
